// *** verilog/epiu_pkg.sv ***
`default_nettype none
package epiu_pkg;
	// register word addresses (byte address = offset, word aligned)
	localparam logic [4:0] OFS_SENSE     = 5'h00;
	localparam logic [4:0] OFS_LINE_EN   = 5'h04;
	localparam logic [4:0] OFS_LINE_FLG  = 5'h08;
	localparam logic [4:0] OFS_GRP_EN    = 5'h0c;
	localparam logic [4:0] OFS_GRP_FLG   = 5'h10;
	localparam logic [4:0] OFS_MASK_HI   = 5'h14;
	localparam logic [4:0] OFS_MASK_LO   = 5'h18;
	localparam logic [4:0] OFS_IRQ_STAT  = 5'h1c;
	// field positions
	localparam int SENSE_B_POS = 2;
	localparam int SENSE_A_POS = 0;
	localparam int GRP_HI_POS  = 1;
	localparam int GRP_LO_POS  = 0;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// timing: a one-cycle bus answer
	localparam int BUS_WAIT_CYC = 1;
	// sense modes
	typedef enum logic [1:0]
	{
		SENSE_LOW  = 2'b00,
		SENSE_ANY  = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} epiu_sense_t;
	// request vector towards the core dispatch
	typedef struct packed
	{
		logic grp_high;
		logic grp_low;
		logic line_b;
		logic line_a;
	} epiu_req_t;
endpackage
`default_nettype wire

// *** verilog/epiu_top.sv ***
// Summary of operation
// - inputs trigger regardless of pin direction
// - masked change on 15..8 requests group high
// - masked change on 7..0 requests group low
// - pin change detection without clocked edge logic; code compares sampled levels on the system clock
// - sense field selects low/any/fall/rise
// - sense bits 3:2 line b, 1:0 line a
// - level mode requests while pin stays low
// - edge detection runs on the system clock
// - level removed early gives no request
// - pins sampled; pulses over one period caught; code needs stages two and three to agree, two clock edges
// - line taken with enable and global enable
// - edge sets flag; ack or write one clears
// - flag reads zero in level mode
// - group taken with enable and global enable
// - group change sets flag; ack or w1c clears
// - mask bits enable inputs, reset zero
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module epiu_top
	import epiu_pkg::*;
(
	input  wire logic              SYS_CLK,
	input  wire logic              RST_B,
	input  wire logic [4:0]        AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	output logic      [31:0]       AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	input  wire logic              EXT_LINE_A,
	input  wire logic              EXT_LINE_B,
	input  wire logic [15:0]       PIN_CHANGE_INPUTS,
	input  wire logic              CORE_GLOBAL_IE,
	input  wire epiu_pkg::epiu_req_t CORE_ACK,
	output epiu_pkg::epiu_req_t    CORE_REQ,
	output logic                   IRQ
);
	import epiu_pkg::*;

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [17:0] s1_q;
	logic [17:0] s2_q;
	logic [17:0] s3_q;
	logic [17:0] raw;
	logic [17:0] stable_q;
	assign raw = {PIN_CHANGE_INPUTS, EXT_LINE_B, EXT_LINE_A};

	// stages reset high like the idle pulled-up pins, so leaving reset makes no false edge
	// pins are read whatever their direction, so driving them works as a soft trigger
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a level counts once stages two and three agree; filters metastable flicker
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			stable_q <= {18{1'b1}};
		else
			stable_q <= (s2_q == s3_q) ? s3_q : stable_q;
	end

	// stable_q resets high, so first compare after reset sees pins as idle high
	logic [17:0] prev_q;
	logic        primed_q;
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			prev_q   <= {18{1'b1}};
			primed_q <= 1'b0;
		end
		else
		begin
			prev_q   <= stable_q;
			primed_q <= 1'b1;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	logic [3:0]  sense_q;
	logic [1:0]  line_en_q;
	logic [1:0]  line_flg_q;
	logic [1:0]  grp_en_q;
	logic [1:0]  grp_flg_q;
	logic [7:0]  mask_hi_q;
	logic [7:0]  mask_lo_q;
	logic        wr_ok;
	logic        ack_q;

	// one wait cycle per access; the second cycle completes it
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			ack_q <= 1'b0;
		else
			ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
	end
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
	assign wr_ok = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];

	function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
		hit = (a == ofs);
	endfunction

	// control registers; only byte lane 0 holds data
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			sense_q   <= RST_BYTE[3:0];
			line_en_q <= RST_BYTE[1:0];
			grp_en_q  <= RST_BYTE[1:0];
			mask_hi_q <= RST_BYTE;
			mask_lo_q <= RST_BYTE;
		end
		else if (wr_ok)
		begin
			if (hit(AVS_ADDRESS, OFS_SENSE))
				sense_q <= AVS_WRITEDATA[3:0];
			else if (hit(AVS_ADDRESS, OFS_LINE_EN))
				line_en_q <= AVS_WRITEDATA[1:0];
			else if (hit(AVS_ADDRESS, OFS_GRP_EN))
				grp_en_q <= AVS_WRITEDATA[1:0];
			else if (hit(AVS_ADDRESS, OFS_MASK_HI))
				mask_hi_q <= AVS_WRITEDATA[7:0];
			else if (hit(AVS_ADDRESS, OFS_MASK_LO))
				mask_lo_q <= AVS_WRITEDATA[7:0];
		end
	end

	// ************************************************************
	// event detection
	// ************************************************************
	epiu_sense_t mode_a;
	epiu_sense_t mode_b;
	assign mode_a = epiu_sense_t'(sense_q[SENSE_A_POS +: 2]);
	assign mode_b = epiu_sense_t'(sense_q[SENSE_B_POS +: 2]);

	// edge kind chosen by the sense field; low level makes no edge event
	function automatic logic edge_hit(input epiu_sense_t m, input logic now, input logic was);
		case (m)
			SENSE_ANY:  edge_hit = now ^ was;
			SENSE_FALL: edge_hit = was && !now;
			SENSE_RISE: edge_hit = now && !was;
			default:    edge_hit = 1'b0;
		endcase
	endfunction

	logic [1:0]  line_evt;
	logic [1:0]  grp_evt;
	logic [15:0] pc_toggle;
	logic [1:0]  line_low;
	assign line_evt[0] = primed_q && edge_hit(mode_a, stable_q[0], prev_q[0]);
	assign line_evt[1] = primed_q && edge_hit(mode_b, stable_q[1], prev_q[1]);
	// pin change is compared against the last level with no clocked edge
	// qualifier beyond the sampling; a true wake path sits outside this block
	assign pc_toggle = (stable_q[17:2] ^ prev_q[17:2]) & {mask_hi_q, mask_lo_q};
	assign grp_evt[GRP_HI_POS] = primed_q && |pc_toggle[15:8];
	assign grp_evt[GRP_LO_POS] = primed_q && |pc_toggle[7:0];
	// level request follows the live sampled level, so a low removed early
	// simply drops the request and nothing is remembered
	assign line_low[0] = (mode_a == SENSE_LOW) && !stable_q[0];
	assign line_low[1] = (mode_b == SENSE_LOW) && !stable_q[1];

	// ************************************************************
	// flags: set wins over both clears
	// ************************************************************
	logic [1:0] line_clr;
	logic [1:0] grp_clr;
	assign line_clr = ({2{wr_ok && hit(AVS_ADDRESS, OFS_LINE_FLG)}} & AVS_WRITEDATA[1:0])
		| {CORE_ACK.line_b, CORE_ACK.line_a};
	assign grp_clr = ({2{wr_ok && hit(AVS_ADDRESS, OFS_GRP_FLG)}} & AVS_WRITEDATA[1:0])
		| {CORE_ACK.grp_high, CORE_ACK.grp_low};

	// level mode holds the flag clear, so software never sees a stale edge
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			line_flg_q <= RST_BYTE[1:0];
		else
		begin
			line_flg_q[0] <= (mode_a == SENSE_LOW) ? 1'b0 : line_evt[0] || (line_flg_q[0] && !line_clr[0]);
			line_flg_q[1] <= (mode_b == SENSE_LOW) ? 1'b0 : line_evt[1] || (line_flg_q[1] && !line_clr[1]);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			grp_flg_q <= RST_BYTE[1:0];
		else
			grp_flg_q <= grp_evt | (grp_flg_q & ~grp_clr);
	end

	// ************************************************************
	// requests to core, gated by local and global enable
	// ************************************************************
	epiu_req_t req;
	always_comb
	begin
		req.line_a   = (line_flg_q[0] || line_low[0]) && line_en_q[0];
		req.line_b   = (line_flg_q[1] || line_low[1]) && line_en_q[1];
		req.grp_low  = grp_flg_q[GRP_LO_POS] && grp_en_q[GRP_LO_POS];
		req.grp_high = grp_flg_q[GRP_HI_POS] && grp_en_q[GRP_HI_POS];
	end
	// a low level must outlast the instruction for the core to see it
	assign CORE_REQ = CORE_GLOBAL_IE ? req : '0;
	assign IRQ = |CORE_REQ;

	// ************************************************************
	// read data
	// ************************************************************
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = '0;
		if (hit(AVS_ADDRESS, OFS_SENSE))
			rd_d[3:0] = sense_q;
		else if (hit(AVS_ADDRESS, OFS_LINE_EN))
			rd_d[1:0] = line_en_q;
		else if (hit(AVS_ADDRESS, OFS_LINE_FLG))
			rd_d[1:0] = line_flg_q;
		else if (hit(AVS_ADDRESS, OFS_GRP_EN))
			rd_d[1:0] = grp_en_q;
		else if (hit(AVS_ADDRESS, OFS_GRP_FLG))
			rd_d[1:0] = grp_flg_q;
		else if (hit(AVS_ADDRESS, OFS_MASK_HI))
			rd_d[7:0] = mask_hi_q;
		else if (hit(AVS_ADDRESS, OFS_MASK_LO))
			rd_d[7:0] = mask_lo_q;
		else if (hit(AVS_ADDRESS, OFS_IRQ_STAT))
			rd_d[3:0] = req;
	end
	// read data is captured in the wait cycle and shown from a flop in the
	// answer cycle; it is one cycle old, which a flag set in between can outrun
	logic [31:0] rd_q;
	always_ff @(posedge SYS_CLK or negedge RST_B)
	begin
		if (!RST_B)
			rd_q <= '0;
		else if (AVS_READ && !ack_q)
			rd_q <= rd_d;
		else
			rd_q <= '0;
	end
	assign AVS_READDATA = rd_q;

	// ************************************************************
	// checks
	// ************************************************************
	// every check runs on the one system clock and rests during reset
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	sequence fall_a_s;
		(mode_a == SENSE_FALL) && primed_q && prev_q[0] && !stable_q[0];
	endsequence

	fall_sets_a: assert property (fall_a_s |=> line_flg_q[0])
		else $error("falling edge did not set line a flag");
	level_flag_zero_a: assert property ((mode_b == SENSE_LOW) |=> !line_flg_q[1] || mode_b != SENSE_LOW)
		else $error("line b flag set in level mode");
	level_req_a: assert property (line_low[0] && line_en_q[0] && CORE_GLOBAL_IE |-> CORE_REQ.line_a)
		else $error("level low not requested");
	global_gate_a: assert property (!CORE_GLOBAL_IE |-> CORE_REQ == '0)
		else $error("request without global enable");
	grp_hi_set_a: assert property (primed_q && |pc_toggle[15:8] |=> grp_flg_q[GRP_HI_POS])
		else $error("group high flag missed");
	grp_lo_set_a: assert property (primed_q && |pc_toggle[7:0] |=> grp_flg_q[GRP_LO_POS])
		else $error("group low flag missed");
	masked_quiet_a: assert property (mask_lo_q == 8'h00 && !grp_flg_q[0] |=> !grp_flg_q[0])
		else $error("masked inputs set group low flag");
	grp_gate_a: assert property (CORE_REQ.grp_high |-> grp_en_q[GRP_HI_POS] && grp_flg_q[GRP_HI_POS])
		else $error("group high request without enable");
	sense_mode_a: assert property ((mode_a == SENSE_RISE) && primed_q && !prev_q[0] && stable_q[0] |=> line_flg_q[0])
		else $error("rising edge missed");
	sample_delay_a: assert property ($rose(s3_q[1]) && s2_q[1] |=> stable_q[1])
		else $error("sampled level not accepted");
	ack_clear_a: assert property (line_flg_q[0] && CORE_ACK.line_a && !line_evt[0] |=> !line_flg_q[0])
		else $error("ack did not clear line a flag");
	req_and_a: assert property (CORE_REQ.grp_low |-> grp_flg_q[0] && grp_en_q[0])
		else $error("group low request without flag");
	low_drop_a: assert property ((mode_a == SENSE_LOW) && stable_q[0] && !line_flg_q[0] |-> !CORE_REQ.line_a)
		else $error("level request after level removed");
	pin_any_a: assert property ($changed(stable_q[2]) && primed_q && mask_lo_q[0] |=> grp_flg_q[GRP_LO_POS])
		else $error("pin change path");

	sequence fall_b_s;
		(mode_b == SENSE_FALL) && primed_q && prev_q[1] && !stable_q[1];
	endsequence

	sequence rise_b_s;
		(mode_b == SENSE_RISE) && primed_q && !prev_q[1] && stable_q[1];
	endsequence

	sequence any_a_s;
		(mode_a == SENSE_ANY) && primed_q && (prev_q[0] != stable_q[0]);
	endsequence

	sequence w1c_b_s;
		wr_ok && hit(AVS_ADDRESS, OFS_LINE_FLG) && AVS_WRITEDATA[1];
	endsequence

	// falling edge on line b latches its flag
	fall_sets_b_a: assert property (fall_b_s |=> line_flg_q[1])
		else $error("falling edge did not set line b flag");

	// rising edge on line b latches its flag
	rise_sets_b_a: assert property (rise_b_s |=> line_flg_q[1])
		else $error("rising edge missed on line b");

	// any change on line a latches its flag
	any_sets_a_a: assert property (any_a_s |=> line_flg_q[0])
		else $error("change missed on line a");

	// write one clears line b flag when no new edge arrives
	w1c_clear_b_a: assert property (w1c_b_s ##0 !line_evt[1] |=> !line_flg_q[1])
		else $error("write one did not clear line b flag");

	// an edge in the clearing cycle still leaves the flag set
	set_wins_a_a: assert property (line_evt[0] && line_clr[0] |=> line_flg_q[0])
		else $error("clear beat a new edge on line a");

	// low level on line b keeps its request up
	level_b_req_a: assert property (line_low[1] && line_en_q[1] && CORE_GLOBAL_IE |-> CORE_REQ.line_b)
		else $error("line b level not requested");

	// line b request needs its enable and the global enable
	line_gate_a: assert property (CORE_REQ.line_b |-> line_en_q[1] && CORE_GLOBAL_IE)
		else $error("line b request without enables");

	// routine entry clears the group low flag
	grp_ack_a: assert property (grp_flg_q[0] && CORE_ACK.grp_low && !grp_evt[0] |=> !grp_flg_q[0])
		else $error("ack did not clear group low flag");

	// write one clears the group high flag
	grp_w1c_a: assert property (wr_ok && hit(AVS_ADDRESS, OFS_GRP_FLG) && AVS_WRITEDATA[1] && !grp_evt[1] |=> !grp_flg_q[1])
		else $error("write one did not clear group high flag");

	// a fully masked high group stays quiet
	mask_hi_quiet_a: assert property (mask_hi_q == 8'h00 && !grp_flg_q[1] |=> !grp_flg_q[1])
		else $error("masked inputs set group high flag");

	// stages two and three agreeing hand the level on
	sync_agree_a: assert property (s2_q[0] == s3_q[0] |=> stable_q[0] == $past(s3_q[0]))
		else $error("agreed level not taken on line a");

	// line a flag reads clear in level mode
	level_zero_a_a: assert property ((mode_a == SENSE_LOW) |=> !line_flg_q[0] || mode_a != SENSE_LOW)
		else $error("line a flag set in level mode");

	// group low request needs the global enable
	grp_lo_gate_a: assert property (CORE_REQ.grp_low |-> CORE_GLOBAL_IE)
		else $error("group low request without global enable");

	// group high request needs the global enable
	grp_hi_gate_a: assert property (CORE_REQ.grp_high |-> CORE_GLOBAL_IE)
		else $error("group high request without global enable");
endmodule
`default_nettype wire

// *** verification/epiu_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// pins and core dispatch outside the block
// ****************************************
module epiu_far_model
	import epiu_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_b,
	input  wire logic [17:0]     pin_cmd,
	input  wire logic            ack_en,
	input  wire epiu_pkg::epiu_req_t req,
	output logic [17:0]          pins,
	output epiu_pkg::epiu_req_t  ack
);
	// pins move only on the clock, so a low level always stands whole cycles
	always_ff @(posedge clk)
	begin
		pins <= pin_cmd;
	end
	// routine entry: one ack pulse for the lowest request, then a quiet cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ack <= '0;
		else if (ack_en && ack == '0)
			ack <= epiu_req_t'(req & ~(req - 4'h1));
		else
			ack <= '0;
	end
endmodule
`default_nettype wire

// *** verification/epiu_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module epiu_top_tb;
	import epiu_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  adr = '0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = '0;
	logic [3:0]  be = '0;
	logic [31:0] rdat;
	logic        wreq;
	logic [17:0] pin_cmd = 18'h3ffff;
	logic [17:0] pins;
	logic        gie = 1'b0;
	logic        ack_en = 1'b0;
	epiu_req_t   ack;
	epiu_req_t   req;
	logic        irq;
	logic [31:0] v;
	int          fails = 0;
	int          n_checks = 0;
	// ****************************************
	// clock, design and far side
	// ****************************************
	always #2 sys_clk = ~sys_clk;
	epiu_top u_epiu_top (.SYS_CLK(sys_clk), .RST_B(rst_b), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .EXT_LINE_A(pins[16]),
		.EXT_LINE_B(pins[17]), .PIN_CHANGE_INPUTS(pins[15:0]), .CORE_GLOBAL_IE(gie),
		.CORE_ACK(ack), .CORE_REQ(req), .IRQ(irq));
	epiu_far_model u_epiu_far_model (.clk(sys_clk), .rst_b(rst_b), .pin_cmd(pin_cmd),
		.ack_en(ack_en), .req(req), .pins(pins), .ack(ack));
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access; the request stands until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] b);
		int n;
		n = 0;
		@(posedge sys_clk);
		adr <= a;
		wdat <= d;
		be <= b;
		rd <= ~w;
		wr <= w;
		@(posedge sys_clk);
		while (wreq !== 1'b0 && n < 64)
		begin
			n++;
			@(posedge sys_clk);
		end
		if (n == 64)
			fails++;
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wrt(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(v, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	// reset values, reserved sense bits, a write with lane 0 off is dropped
	task automatic t_regs();
		for (int i = 0; i < 8; i++)
			rdc(5'(i * 4), 32'h0);
		wrt(OFS_SENSE, 32'hff);
		rdc(OFS_SENSE, 32'h0f);
		bus(1'b1, OFS_MASK_LO, 32'h5a, 4'he);
		rdc(OFS_MASK_LO, 32'h0);
		wrt(OFS_MASK_HI, 32'ha5);
		rdc(OFS_MASK_HI, 32'ha5);
		wrt(OFS_MASK_HI, 32'h0);
	endtask
	// every edge mode on both lines: fall then rise, flag and request
	task automatic t_edge();
		int e;
		for (int i = 0; i < 2; i++)
			for (int m = 1; m < 4; m++)
			begin
				wrt(OFS_SENSE, 32'(m << (2 * i)));
				wrt(OFS_LINE_EN, 32'(1 << i));
				pin_cmd[16 + i] <= 1'b0;
				wait_cyc(8);
				e = int'(m != 3);
				rdc(OFS_LINE_FLG, 32'(e << i));
				chk(32'({irq, req}), 32'({e[0], 4'(e << i)}));
				wrt(OFS_LINE_FLG, 32'(1 << i));
				pin_cmd[16 + i] <= 1'b1;
				wait_cyc(8);
				e = int'(m != 2);
				rdc(OFS_LINE_FLG, 32'(e << i));
				wrt(OFS_LINE_FLG, 32'(1 << i));
				rdc(OFS_LINE_FLG, 32'h0);
			end
	endtask
	// low level keeps requesting, flag stays clear, global enable gates
	task automatic t_level();
		wrt(OFS_SENSE, 32'h0);
		wrt(OFS_LINE_EN, 32'h1);
		pin_cmd[16] <= 1'b0;
		wait_cyc(8);
		repeat (3)
		begin
			chk(32'(req), 32'h1);
			wait_cyc(5);
		end
		rdc(OFS_LINE_FLG, 32'h0);
		gie <= 1'b0;
		wait_cyc(1);
		chk(32'({irq, req}), 32'h0);
		rdc(OFS_IRQ_STAT, 32'h1);
		gie <= 1'b1;
		pin_cmd[16] <= 1'b1;
		wait_cyc(8);
		chk(32'(req), 32'h0);
		wrt(OFS_LINE_EN, 32'h0);
	endtask
	// masked and unmasked inputs in both groups, short pulse, group enables
	task automatic t_pin();
		wrt(OFS_MASK_LO, 32'h08);
		wrt(OFS_MASK_HI, 32'h80);
		wrt(OFS_GRP_EN, 32'h3);
		pin_cmd[4] <= 1'b0;
		pin_cmd[14] <= 1'b0;
		wait_cyc(8);
		rdc(OFS_GRP_FLG, 32'h0);
		pin_cmd[3] <= 1'b0;
		wait_cyc(3);
		pin_cmd[3] <= 1'b1;
		wait_cyc(8);
		rdc(OFS_GRP_FLG, 32'h1);
		chk(32'(req), 32'h4);
		pin_cmd[15] <= 1'b0;
		wait_cyc(8);
		rdc(OFS_GRP_FLG, 32'h3);
		chk(32'({irq, req}), 32'h1c);
		wrt(OFS_GRP_EN, 32'h2);
		wait_cyc(1);
		chk(32'(req), 32'h8);
		wrt(OFS_GRP_FLG, 32'h3);
		rdc(OFS_GRP_FLG, 32'h0);
	endtask
	// a line with its enable off stays quiet, then the core's acks clear both flags
	task automatic t_ack();
		wrt(OFS_SENSE, 32'h8);
		wrt(OFS_GRP_EN, 32'h3);
		pin_cmd[17] <= 1'b0;
		pin_cmd[3] <= 1'b0;
		wait_cyc(8);
		chk(32'({irq, req}), 32'h14);
		rdc(OFS_LINE_FLG, 32'h2);
		wrt(OFS_LINE_EN, 32'h2);
		ack_en <= 1'b1;
		wait_cyc(8);
		ack_en <= 1'b0;
		rdc(OFS_LINE_FLG, 32'h0);
		rdc(OFS_GRP_FLG, 32'h0);
		chk(32'(irq), 32'h0);
	endtask
	// ****************************************
	// run control
	// ****************************************
	task automatic end_sim();
		if (fails == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence after five reset cycles
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		gie <= 1'b1;
		wait_cyc(2);
		t_regs();
		t_edge();
		t_level();
		t_pin();
		t_ack();
		end_sim();
	end
	// watchdog: the whole run needs well under a thousand cycles
	initial
	begin
		#20000;
		fails++;
		end_sim();
	end
endmodule
`default_nettype wire
